// *** common/lsc_pkg.sv ***
/*
  Constants and types for the light sensor conversion control block.
  Assumes a 25 MHz core clock and a 16-bit configuration word.
*/
package lsc_pkg;
  // ----------------------------------------------------------------
  // configuration word field positions
  // ----------------------------------------------------------------
  localparam int RANGE_MSB = 15;
  localparam int RANGE_LSB = 12;
  localparam int CT_BIT = 11;
  localparam int MODE_MSB = 10;
  localparam int MODE_LSB = 9;
  localparam int OVF_BIT = 8;
  localparam int CRF_BIT = 7;
  localparam int FH_BIT = 6;
  localparam int FL_BIT = 5;
  localparam int LOWCFG_MSB = 4;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [3:0] RANGE_AUTO = 4'hc;
  localparam logic [3:0] RANGE_MAX = 4'hb;
  localparam logic [3:0] RANGE_MIN = 4'h0;
  localparam logic [3:0] RANGE_MIDLOW = 4'h5;
  localparam logic [3:0] RANGE_RESET = 4'hc;
  localparam logic CT_RESET = 1'b1;
  localparam logic [4:0] LOWCFG_RESET = 5'h10;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CONV_SHORT_MS = 100;
  localparam int unsigned CONV_LONG_MS = 800;
  localparam int unsigned CONV_SHORT_CYCLES = CONV_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned CONV_LONG_CYCLES = CONV_LONG_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 25;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_CONT_A = 2'b10,
    MODE_CONT_B = 2'b11
  } lsc_mode_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } lsc_state_t;

  localparam lsc_mode_t MODE_RESET = MODE_SHUTDOWN;
endpackage : lsc_pkg

// *** hw/lsc_conversion_control.sv ***
/*
  Conversion control of a light sensor: configuration word, range
  selection with automatic ranging, conversion timing and mode.
  Assumes the serial port decodes register access into a one-cycle
  write strobe and reads the word combinationally; the converter front
  end presents mantissa and overflow on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lsc_conversion_control #(
  parameter int unsigned SHORT_CYCLES = lsc_pkg::CONV_SHORT_CYCLES,
  parameter int unsigned LONG_CYCLES = lsc_pkg::CONV_LONG_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cfgWrEn,
  input wire logic [15:0] cfgWrData,
  output logic [15:0] cfgRdData,
  input wire logic adcOverflow,
  input wire logic [11:0] adcMantissa,
  input wire logic flagReady,
  input wire logic flagHigh,
  input wire logic flagLow,
  output logic [15:0] resultData,
  output logic convDone,
  output logic convActive,
  output logic [3:0] convRange,
  output logic convLong,
  output logic [1:0] resLossBits
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0] rangeSel_q, rangeSel_d;
  logic ctSel_q, ctSel_d;
  lsc_pkg::lsc_mode_t mode_q, mode_d;
  logic overflowFlag_q, overflowFlag_d;
  logic [4:0] lowCfg_q, lowCfg_d;
  lsc_pkg::lsc_state_t state_q, state_d;
  logic [lsc_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [3:0] autoRange_q, autoRange_d;
  logic [15:0] result_q, result_d;
  logic done_q, done_d;
  logic autoMode;
  logic [3:0] effRange;
  logic [lsc_pkg::CNT_W-1:0] lastCnt;
  logic endCnt;
  lsc_pkg::lsc_mode_t wrMode;

  assign autoMode = (rangeSel_q == lsc_pkg::RANGE_AUTO);
  assign effRange = autoMode ? autoRange_q : rangeSel_q;
  assign lastCnt = ctSel_q ? lsc_pkg::CNT_W'(LONG_CYCLES - 1)
                           : lsc_pkg::CNT_W'(SHORT_CYCLES - 1);
  assign endCnt = (state_q == lsc_pkg::ST_CONV) && (cnt_q == lastCnt);
  assign wrMode = lsc_pkg::lsc_mode_t'(cfgWrData[lsc_pkg::MODE_MSB:lsc_pkg::MODE_LSB]);

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    rangeSel_d = rangeSel_q;
    ctSel_d = ctSel_q;
    mode_d = mode_q;
    overflowFlag_d = overflowFlag_q;
    lowCfg_d = lowCfg_q;
    state_d = state_q;
    cnt_d = cnt_q;
    autoRange_d = autoRange_q;
    result_d = result_q;
    done_d = 1'b0;
    if (cfgWrEn) begin
      // abort and optionally restart; flags not touched
      rangeSel_d = cfgWrData[lsc_pkg::RANGE_MSB:lsc_pkg::RANGE_LSB];
      ctSel_d = cfgWrData[lsc_pkg::CT_BIT];
      mode_d = wrMode;
      lowCfg_d = cfgWrData[lsc_pkg::LOWCFG_MSB:0];
      cnt_d = '0;
      autoRange_d = lsc_pkg::RANGE_MIN;
      state_d = (wrMode == lsc_pkg::MODE_SHUTDOWN) ? lsc_pkg::ST_IDLE
                                                   : lsc_pkg::ST_CONV;
    end else if (state_q == lsc_pkg::ST_CONV) begin
      cnt_d = cnt_q + 1'b1;
      if (endCnt) begin
        cnt_d = '0;
        if (autoMode && adcOverflow && (autoRange_q < lsc_pkg::RANGE_MAX)) begin
          autoRange_d = autoRange_q + 1'b1;
        end else begin
          result_d = {effRange, adcMantissa};
          overflowFlag_d = adcOverflow;
          done_d = 1'b1;
          autoRange_d = lsc_pkg::RANGE_MIN;
          if (mode_q == lsc_pkg::MODE_SINGLE) begin
            mode_d = lsc_pkg::MODE_SHUTDOWN;
            state_d = lsc_pkg::ST_IDLE;
          end
          // continuous codes stay converting
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rangeSel_q <= lsc_pkg::RANGE_RESET;
      ctSel_q <= lsc_pkg::CT_RESET;
      mode_q <= lsc_pkg::MODE_RESET;
      overflowFlag_q <= 1'b0;
      lowCfg_q <= lsc_pkg::LOWCFG_RESET;
      state_q <= lsc_pkg::ST_IDLE;
      cnt_q <= '0;
      autoRange_q <= lsc_pkg::RANGE_MIN;
      result_q <= '0;
      done_q <= 1'b0;
    end else begin
      rangeSel_q <= rangeSel_d;
      ctSel_q <= ctSel_d;
      mode_q <= mode_d;
      overflowFlag_q <= overflowFlag_d;
      lowCfg_q <= lowCfg_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      autoRange_q <= autoRange_d;
      result_q <= result_d;
      done_q <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // resolution and outputs
  // ----------------------------------------------------------------
  always_comb begin
    resLossBits = 2'h0;
    if (!ctSel_q) begin
      if (effRange == lsc_pkg::RANGE_MIN) begin
        resLossBits = 2'h3;
      end else if (effRange < lsc_pkg::RANGE_MIDLOW) begin
        resLossBits = 2'h2;
      end else if (effRange == lsc_pkg::RANGE_MIDLOW) begin
        resLossBits = 2'h1;
      end
    end
  end

  assign cfgRdData = {rangeSel_q, ctSel_q, mode_q, overflowFlag_q,
                      flagReady, flagHigh, flagLow, lowCfg_q};
  assign resultData = result_q;
  assign convDone = done_q;
  assign convActive = (state_q == lsc_pkg::ST_CONV);
  assign convRange = effRange;
  assign convLong = ctSel_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic firstCycle_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      firstCycle_q <= 1'b1;
    end else begin
      firstCycle_q <= 1'b0;
    end
  end

  property p_reset_word;
    @(posedge clk) disable iff (!rstn)
      firstCycle_q |-> cfgRdData[15:8] == 8'hc8 && !convActive;
  endproperty
  a_reset_word: assert property (p_reset_word) else $error("reset config wrong");

  property p_fixed_range;
    @(posedge clk) disable iff (!rstn)
      !autoMode |-> convRange == rangeSel_q;
  endproperty
  a_fixed_range: assert property (p_fixed_range) else $error("fixed range not used");

  property p_result_exp;
    @(posedge clk) disable iff (!rstn)
      convDone |-> resultData[15:12] == $past(effRange) && resultData[15:12] <= 4'hb;
  endproperty
  a_result_exp: assert property (p_result_exp) else $error("exponent mismatch");

  property p_loss;
    @(posedge clk) disable iff (!rstn)
      (convLong |-> resLossBits == 2'h0) and
      (!convLong && convRange == 4'h0 |-> resLossBits == 2'h3) and
      (!convLong && convRange > 4'h5 |-> resLossBits == 2'h0);
  endproperty
  a_loss: assert property (p_loss) else $error("resolution loss wrong");

  property p_shutdown_idle;
    @(posedge clk) disable iff (!rstn)
      mode_q == lsc_pkg::MODE_SHUTDOWN && !cfgWrEn |=> !convActive;
  endproperty
  a_shutdown_idle: assert property (p_shutdown_idle) else $error("converting in shutdown");

  property p_single_clear;
    @(posedge clk) disable iff (!rstn)
      endCnt && !cfgWrEn && mode_q == lsc_pkg::MODE_SINGLE && !(autoMode && adcOverflow
      && autoRange_q < 4'hb) |=> convDone && cfgRdData[10:9] == 2'b00 && !convActive;
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("single shot not cleared");

  property p_flags_kept;
    @(posedge clk) disable iff (!rstn)
      (!convDone |-> $stable(overflowFlag_q)) and
      (cfgRdData[7:5] == {flagReady, flagHigh, flagLow});
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags disturbed");

  property p_continuous;
    @(posedge clk) disable iff (!rstn)
      convDone && mode_q[1] && !$past(cfgWrEn) |-> convActive && cnt_q == '0;
  endproperty
  a_continuous: assert property (p_continuous) else $error("continuous stopped");

  property p_write_restart;
    @(posedge clk) disable iff (!rstn)
      cfgWrEn && cfgWrData[10:9] != 2'b00 |=> convActive && cnt_q == '0 && !convDone;
  endproperty
  a_write_restart: assert property (p_write_restart) else $error("write did not restart");

  property p_auto_step;
    @(posedge clk) disable iff (!rstn)
      endCnt && autoMode && adcOverflow && autoRange_q < 4'hb && !cfgWrEn
      |=> !convDone && autoRange_q == $past(autoRange_q) + 4'h1 && convActive;
  endproperty
  a_auto_step: assert property (p_auto_step) else $error("auto range not raised");

  // conversion length measured from its start
  logic [lsc_pkg::CNT_W-1:0] runLen_q, runLen_d;
  always_comb begin
    runLen_d = runLen_q;
    if (cfgWrEn) begin
      runLen_d = '0;
    end else if (convActive) begin
      runLen_d = convDone ? lsc_pkg::CNT_W'(1) : runLen_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      runLen_q <= '0;
    end else begin
      runLen_q <= runLen_d;
    end
  end

  property p_conv_len;
    @(posedge clk) disable iff (!rstn)
      convDone && !autoMode |->
        32'(runLen_q) == (convLong ? LONG_CYCLES : SHORT_CYCLES);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_single_hold;
    @(posedge clk) disable iff (!rstn)
      cfgRdData[lsc_pkg::MODE_MSB:lsc_pkg::MODE_LSB] == lsc_pkg::MODE_SINGLE |-> convActive;
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("mode 01 idle");

  property p_cont_busy;
    @(posedge clk) disable iff (!rstn)
      mode_q == lsc_pkg::MODE_CONT_A || mode_q == lsc_pkg::MODE_CONT_B |-> convActive;
  endproperty
  a_cont_busy: assert property (p_cont_busy) else $error("continuous mode idle");

  property p_auto_ovf;
    @(posedge clk) disable iff (!rstn)
      convDone && autoMode && overflowFlag_q |-> resultData[15:12] == lsc_pkg::RANGE_MAX;
  endproperty
  a_auto_ovf: assert property (p_auto_ovf) else $error("auto overflow below max");

  property p_auto_start;
    @(posedge clk) disable iff (!rstn)
      cfgWrEn && cfgWrData[lsc_pkg::RANGE_MSB:lsc_pkg::RANGE_LSB] == lsc_pkg::RANGE_AUTO
      |=> autoMode && convRange == lsc_pkg::RANGE_MIN;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("auto range not restarted");

  c_single: cover property (@(posedge clk) disable iff (!rstn)
    convDone && mode_q == lsc_pkg::MODE_SHUTDOWN);
  c_continuous: cover property (@(posedge clk) disable iff (!rstn)
    convDone && mode_q[1]);
  c_auto_step: cover property (@(posedge clk) disable iff (!rstn)
    autoMode && autoRange_q == 4'h2);
  c_abort: cover property (@(posedge clk) disable iff (!rstn)
    cfgWrEn && convActive);
endmodule : lsc_conversion_control
`default_nettype wire

// *** tb/lsc_host_model.sv ***
/*
  Host side model: writes configuration words with a one-cycle strobe.
  Assumes a free running clock and that the bench calls write().
*/
`timescale 1ns/1ps
`default_nettype none
module lsc_host_model (
  input wire logic clk,
  output logic cfgWrEn,
  output logic [15:0] cfgWrData
);
  initial begin
    cfgWrEn = 1'b0;
    cfgWrData = 16'h0000;
  end

  // ----------------------------------------------------------------
  // write cycle, launched at the falling edge
  // ----------------------------------------------------------------
  task automatic write(input logic [15:0] word);
    @(negedge clk);
    if (word[15:12] > 4'hc) word[15:12] = 4'hc;
    cfgWrEn = 1'b1;
    cfgWrData = word;
    @(negedge clk);
    cfgWrEn = 1'b0;
    cfgWrData = ~word;
  endtask : write
endmodule : lsc_host_model
`default_nettype wire

// *** tb/tb.sv ***
/*
  Self-checking bench for the conversion control block.
  Assumes short and long conversions shortened to 4 and 8 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rstn, cfgWrEn, adcOverflow, flagReady, flagHigh, flagLow;
  logic [15:0] cfgWrData, cfgRdData, resultData;
  logic [11:0] adcMantissa;
  logic convDone, convActive, convLong;
  logic [3:0] convRange;
  logic [1:0] resLossBits;
  int nFail, nTests, cyc;

  lsc_conversion_control #(.SHORT_CYCLES(4), .LONG_CYCLES(8)) lsc_conversion_control_inst (
    .clk(clk), .rstn(rstn), .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .adcOverflow(adcOverflow), .adcMantissa(adcMantissa), .flagReady(flagReady),
    .flagHigh(flagHigh), .flagLow(flagLow), .resultData(resultData), .convDone(convDone),
    .convActive(convActive), .convRange(convRange), .convLong(convLong),
    .resLossBits(resLossBits));
  lsc_host_model lsc_host_model_inst (.clk(clk), .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData));

  // ----------------------------------------------------------------
  // compare and wait helpers
  // ----------------------------------------------------------------
  task automatic testDone();
    $display("tests %0d fails %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : testDone

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      nFail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_cyc(input int got, input int exp);
    nTests++;
    if (got != exp) begin
      nFail++;
      $display("BAD %0t latency %0d exp %0d", $time, got, exp);
    end
  endtask : chk_cyc

  task automatic wait_done();
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (convDone !== 1'b1 && cyc < 200);
    if (cyc >= 200) begin
      nFail++;
      $display("BAD %0t no completion", $time);
      testDone();
    end
  endtask : wait_done

  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk);
      chk({15'h0, convDone}, 16'h0);
    end
  endtask : quiet

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset(input logic [2:0] fl);
    rstn = 1'b0;
    {flagReady, flagHigh, flagLow} = fl;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    chk(cfgRdData, {8'hc8, fl, 5'h10});
    chk({14'h0, convLong, convActive}, 16'h2);
    quiet(12);
  endtask : t_reset

  task automatic t_fixed(input logic ct);
    logic [1:0] loss;
    for (int r = 0; r < 12; r++) begin
      adcMantissa = 12'ha50 + 12'(r);
      {flagReady, flagHigh, flagLow} = 3'(r);
      loss = ct ? 2'd0 : (r > 5) ? 2'd0 : (r == 5) ? 2'd1 : (r >= 1) ? 2'd2 : 2'd3;
      lsc_host_model_inst.write({4'(r), ct, 2'b01, 9'h010});
      chk({14'h0, cfgRdData[10:9]}, 16'h1);
      chk({12'h0, convRange}, 16'(r));
      chk({13'h0, convLong, resLossBits}, {13'h0, ct, loss});
      wait_done();
      chk_cyc(cyc, ct ? 8 : 4);
      chk(resultData, {4'(r), 12'ha50 + 12'(r)});
      chk({9'h0, cfgRdData[10:5], convActive}, {12'h0, 3'(r), 1'b0});
    end
  endtask : t_fixed

  task automatic t_auto();
    adcOverflow = 1'b1;
    {flagReady, flagHigh, flagLow} = 3'b111;
    lsc_host_model_inst.write(16'hc210);
    wait_done();
    chk_cyc(cyc, 48);
    chk({12'h0, resultData[15:12]}, 16'hb);
    quiet(3);
    chk({12'h0, cfgRdData[8:5]}, 16'hf);
    adcOverflow = 1'b0;
    lsc_host_model_inst.write(16'hc210);
    wait_done();
    chk_cyc(cyc, 4);
    chk({11'h0, resultData[15:12], cfgRdData[8]}, 16'h0);
  endtask : t_auto

  task automatic t_cont();
    for (int m = 2; m < 4; m++) begin
      lsc_host_model_inst.write({4'h2, 1'b0, 2'(m), 9'h010});
      wait_done();
      chk_cyc(cyc, 4);
      wait_done();
      chk_cyc(cyc, 4);
      chk({14'h0, cfgRdData[10:9]}, 16'(m));
    end
    lsc_host_model_inst.write(16'h2010);
    chk({12'h0, cfgRdData[8:5]}, 16'h7);
    chk({15'h0, convActive}, 16'h0);
    quiet(10);
  endtask : t_cont

  task automatic t_abort();
    lsc_host_model_inst.write(16'h3210);
    @(negedge clk);
    lsc_host_model_inst.write(16'h4210);
    wait_done();
    chk_cyc(cyc, 4);
    chk({12'h0, resultData[15:12]}, 16'h4);
    quiet(8);
  endtask : t_abort

  task automatic t_midreset();
    lsc_host_model_inst.write(16'h2410);
    chk({15'h0, convActive}, 16'h1);
    t_reset(3'b101);
  endtask : t_midreset

  // ----------------------------------------------------------------
  // clock, reset and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    adcOverflow = 1'b0;
    adcMantissa = 12'h000;
    nFail = 0;
    nTests = 0;
    t_reset(3'b000);
    t_fixed(1'b0);
    t_fixed(1'b1);
    t_auto();
    t_cont();
    t_abort();
    t_midreset();
    testDone();
  end
endmodule : tb
`default_nettype wire
